// ===== rtl/gppwm_top.sv
/*
  General pin unit: per-pin direction, drive, pull and level wake, two
  alternate-function channels (PWM or square wave) and a filtered reset pin.
  Assumes an AHB-Lite master on hclk; pad cells resolve the pin enables.
*/
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps

// Overview of operation
// - Every pin configured independently of others
// - Per-pin direction: input or output
// - Per-pin drive strength: standard or high
// - Per-pin pull: up, down or none
// - Per-pin level wake, selectable active level
// - Alternate function replaces output data with waveform
// - At most two pins carry alternate functions
// - PWM counts microseconds in 32-bit counter
// - PWM up to 1 MHz, duty 0-100%
// - Shared PWM period, separate duty per pin
// - Square wave 0 Hz-4 MHz, equal halves
// - Reset pin must stay low 100 ms
module gppwm_top
  import gppwm_pkg::*;
#(
  parameter int RST_HOLD_CYC = RST_MIN_CYC
)(
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic [NUM_PINS-1:0] general_pin_in,
  output logic      [NUM_PINS-1:0] general_pin_out,
  output logic      [NUM_PINS-1:0] general_pin_oe_n,
  output logic      [NUM_PINS-1:0] general_pin_drive_hi,
  output logic      [NUM_PINS-1:0] general_pin_pull_up,
  output logic      [NUM_PINS-1:0] general_pin_pull_dn,
  output logic                     wake_req,
  input  wire logic                hw_reset_in_n,
  output logic                     core_reset
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] dir_ff, nxt_dir, dout_ff, nxt_dout, drive_ff, nxt_drive;
  logic [NUM_PINS-1:0] wake_en_ff, nxt_wake_en, wake_lvl_ff, nxt_wake_lvl;
  logic [15:0]         pull_ff, nxt_pull, func_ff, nxt_func;
  logic [31:0]         period_ff, nxt_period, duty0_ff, nxt_duty0, duty1_ff, nxt_duty1;
  logic [31:0]         sqw_half_ff, nxt_sqw_half;
  logic                wr_pend_ff, nxt_wr_pend;
  logic [7:0]          wr_addr_ff, nxt_wr_addr;
  logic [31:0]         hrdata_ff, nxt_hrdata, rd_val;
  logic                hreadyout_ff, hresp_ff;
  logic                acc;
  logic [NUM_PINS-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_f_ff, nxt_pin_f;
  logic [NUM_PINS-1:0] out_ff, nxt_out, oe_n_ff, nxt_oe_n, drv_ff, nxt_drv;
  logic [NUM_PINS-1:0] pu_ff, nxt_pu, pd_ff, nxt_pd, mask0, mask1;
  logic                wake_ff, nxt_wake;
  logic [5:0]          tick_cnt_ff, nxt_tick_cnt;
  logic                tick_ff, nxt_tick;
  logic [1:0]          pwm_w;
  logic                sqw_w;
  logic                rst_s1_ff, rst_s2_ff, rst_s3_ff, rst_f_ff, nxt_rst_f;
  logic [31:0]         low_cnt_ff, nxt_low_cnt;
  logic                core_rst_ff, nxt_core_rst;

  // Pin mask of one alternate channel, empty when its mode is off
  function automatic logic [NUM_PINS-1:0] alt_mask(input logic [FUNC_CH_W-1:0] f);
    logic [1:0] md;
    md = f[FUNC_MODE_LSB +: 2];
    alt_mask = '0;
    if (md == GPPWM_MODE_PWM || md == GPPWM_MODE_SQW) begin
      alt_mask[f[FUNC_PIN_LSB +: 3]] = 1'b1;
    end
  endfunction

  // Waveform of one alternate channel
  function automatic logic alt_wave(input logic [FUNC_CH_W-1:0] f, input logic pwm, input logic sqw);
    alt_wave = (f[FUNC_MODE_LSB +: 2] == GPPWM_MODE_SQW) ? sqw : pwm;
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  assign acc = hsel & htrans[1] & hready;

  always_comb begin
    nxt_wr_pend = acc & hwrite;
    nxt_wr_addr = acc ? haddr[7:0] : wr_addr_ff;
    // Read from next values so a read right after a write sees it
    unique case (haddr[7:0])
      REG_DIR:      rd_val = {24'h0, nxt_dir};
      REG_DOUT:     rd_val = {24'h0, nxt_dout};
      REG_DRIVE:    rd_val = {24'h0, nxt_drive};
      REG_PULL:     rd_val = {16'h0, nxt_pull};
      REG_WAKE_EN:  rd_val = {24'h0, nxt_wake_en};
      REG_WAKE_LVL: rd_val = {24'h0, nxt_wake_lvl};
      REG_FUNC:     rd_val = {16'h0, nxt_func};
      REG_PERIOD:   rd_val = nxt_period;
      REG_DUTY0:    rd_val = nxt_duty0;
      REG_DUTY1:    rd_val = nxt_duty1;
      REG_SQW_HALF: rd_val = nxt_sqw_half;
      REG_STATUS:   rd_val = {22'h0, core_rst_ff, wake_ff, pin_f_ff};
      default:      rd_val = 32'h0;
    endcase
    nxt_hrdata = (acc & ~hwrite) ? rd_val : hrdata_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
      hrdata_ff    <= 32'h0;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      wr_pend_ff   <= nxt_wr_pend;
      wr_addr_ff   <= nxt_wr_addr;
      hrdata_ff    <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Per-pin bit fields, function select and waveform timing words
  always_comb begin
    nxt_dir = dir_ff;       nxt_dout = dout_ff;         nxt_drive = drive_ff;
    nxt_pull = pull_ff;     nxt_wake_en = wake_en_ff;   nxt_wake_lvl = wake_lvl_ff;
    nxt_func = func_ff;     nxt_period = period_ff;     nxt_sqw_half = sqw_half_ff;
    nxt_duty0 = duty0_ff;   nxt_duty1 = duty1_ff;
    if (core_rst_ff) begin
      nxt_dir = RST_PINS;   nxt_dout = RST_PINS;        nxt_drive = RST_PINS;
      nxt_pull = RST_PULL;  nxt_wake_en = RST_PINS;     nxt_wake_lvl = RST_PINS;
      nxt_func = RST_FUNC;  nxt_period = RST_WORD;      nxt_sqw_half = RST_WORD;
      nxt_duty0 = RST_WORD; nxt_duty1 = RST_WORD;
    end else if (wr_pend_ff) begin
      case (wr_addr_ff)
        REG_DIR:      nxt_dir = hwdata[NUM_PINS-1:0];
        REG_DOUT:     nxt_dout = hwdata[NUM_PINS-1:0];
        REG_DRIVE:    nxt_drive = hwdata[NUM_PINS-1:0];
        REG_PULL:     nxt_pull = hwdata[15:0];
        REG_WAKE_EN:  nxt_wake_en = hwdata[NUM_PINS-1:0];
        REG_WAKE_LVL: nxt_wake_lvl = hwdata[NUM_PINS-1:0];
        REG_FUNC:     nxt_func = hwdata[15:0];
        REG_PERIOD:   nxt_period = hwdata;
        REG_DUTY0:    nxt_duty0 = hwdata;
        REG_DUTY1:    nxt_duty1 = hwdata;
        REG_SQW_HALF: nxt_sqw_half = hwdata;
        default:      nxt_dir = dir_ff;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_ff <= RST_PINS;   dout_ff <= RST_PINS;        drive_ff <= RST_PINS;
      pull_ff <= RST_PULL;  wake_en_ff <= RST_PINS;     wake_lvl_ff <= RST_PINS;
      func_ff <= RST_FUNC;  period_ff <= RST_WORD;      sqw_half_ff <= RST_WORD;
      duty0_ff <= RST_WORD; duty1_ff <= RST_WORD;
    end else begin
      dir_ff <= nxt_dir;    dout_ff <= nxt_dout;        drive_ff <= nxt_drive;
      pull_ff <= nxt_pull;  wake_en_ff <= nxt_wake_en;  wake_lvl_ff <= nxt_wake_lvl;
      func_ff <= nxt_func;  period_ff <= nxt_period;    sqw_half_ff <= nxt_sqw_half;
      duty0_ff <= nxt_duty0; duty1_ff <= nxt_duty1;
    end
  end

  // ----------------------------------------------------------------
  // 1 MHz tick and waveform engines
  // ----------------------------------------------------------------
  // Tick from bus clock divide
  always_comb begin
    nxt_tick     = (tick_cnt_ff == 6'(TICK_DIV - 1));
    nxt_tick_cnt = nxt_tick ? 6'h00 : tick_cnt_ff + 6'h01;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_ff <= 6'h00;
      tick_ff     <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff     <= nxt_tick;
    end
  end

  gppwm_pwm u_pwm (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick_ff),
    .period  (period_ff),
    .duty0   (duty0_ff),
    .duty1   (duty1_ff),
    .pwm_out (pwm_w)
  );

  gppwm_sqw u_sqw (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .half_cyc (sqw_half_ff),
    .sqw_out  (sqw_w)
  );

  // ----------------------------------------------------------------
  // Pin input filter and pin drive
  // ----------------------------------------------------------------
  always_comb begin
    // Accept a change only once the second and third stages agree
    nxt_pin_f = pin_f_ff;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_s2_ff[i] == pin_s3_ff[i]) begin
        nxt_pin_f[i] = pin_s3_ff[i];
      end
    end
    // Two channels, channel 0 wins a shared pin
    mask0 = alt_mask(func_ff[0 +: FUNC_CH_W]);
    mask1 = alt_mask(func_ff[FUNC_CH_W +: FUNC_CH_W]) & ~mask0;
    nxt_out  = (dout_ff & ~(mask0 | mask1))
             | (mask0 & {NUM_PINS{alt_wave(func_ff[0 +: FUNC_CH_W], pwm_w[0], sqw_w)}})
             | (mask1 & {NUM_PINS{alt_wave(func_ff[FUNC_CH_W +: FUNC_CH_W], pwm_w[1], sqw_w)}});
    // Direction, forced out on alternate pins
    nxt_oe_n = ~(dir_ff | mask0 | mask1);
    nxt_drv  = drive_ff;
    for (int i = 0; i < NUM_PINS; i++) begin
      nxt_pu[i] = (pull_ff[2*i +: 2] == PULL_UP);
      nxt_pd[i] = (pull_ff[2*i +: 2] == PULL_DOWN);
    end
    nxt_wake = |(wake_en_ff & ~(pin_f_ff ^ wake_lvl_ff));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_ff <= RST_PINS; pin_s2_ff <= RST_PINS; pin_s3_ff <= RST_PINS;
      pin_f_ff  <= RST_PINS; out_ff <= RST_PINS;    oe_n_ff <= ~RST_PINS;
      drv_ff    <= RST_PINS; pu_ff <= RST_PINS;     pd_ff <= RST_PINS;
      wake_ff   <= 1'b0;
    end else begin
      pin_s1_ff <= general_pin_in; pin_s2_ff <= pin_s1_ff; pin_s3_ff <= pin_s2_ff;
      pin_f_ff  <= nxt_pin_f;      out_ff <= nxt_out;      oe_n_ff <= nxt_oe_n;
      drv_ff    <= nxt_drv;        pu_ff <= nxt_pu;        pd_ff <= nxt_pd;
      wake_ff   <= nxt_wake;
    end
  end

  // ----------------------------------------------------------------
  // Reset pin qualification
  // ----------------------------------------------------------------
  // Ignore pulses shorter than the hold time
  always_comb begin
    nxt_rst_f    = (rst_s2_ff == rst_s3_ff) ? rst_s3_ff : rst_f_ff;
    nxt_low_cnt  = 32'h0;
    nxt_core_rst = 1'b0;
    if (!rst_f_ff) begin
      nxt_low_cnt  = (low_cnt_ff == 32'(RST_HOLD_CYC)) ? low_cnt_ff : low_cnt_ff + 32'h1;
      nxt_core_rst = (nxt_low_cnt == 32'(RST_HOLD_CYC));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_s1_ff   <= 1'b1;
      rst_s2_ff   <= 1'b1;
      rst_s3_ff   <= 1'b1;
      rst_f_ff    <= 1'b1;
      low_cnt_ff  <= 32'h0;
      core_rst_ff <= 1'b0;
    end else begin
      rst_s1_ff   <= hw_reset_in_n;
      rst_s2_ff   <= rst_s1_ff;
      rst_s3_ff   <= rst_s2_ff;
      rst_f_ff    <= nxt_rst_f;
      low_cnt_ff  <= nxt_low_cnt;
      core_rst_ff <= nxt_core_rst;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata               = hrdata_ff;
  assign hreadyout            = hreadyout_ff;
  assign hresp                = hresp_ff;
  assign general_pin_out      = out_ff;
  assign general_pin_oe_n     = oe_n_ff;
  assign general_pin_drive_hi = drv_ff;
  assign general_pin_pull_up  = pu_ff;
  assign general_pin_pull_dn  = pd_ff;
  assign wake_req             = wake_ff;
  assign core_reset           = core_rst_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reset_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(core_rst_ff) |-> (low_cnt_ff == 32'(RST_HOLD_CYC)) && !$past(rst_f_ff))
    else $error("Core reset without full low hold");

  a_dir_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 (oe_n_ff & $past(dir_ff)) == '0)
    else $error("Output pin not driven");

  a_pull_excl: assert property (@(posedge hclk) disable iff (!hresetn)
    (pu_ff & pd_ff) == '0 ##1 (pu_ff & pd_ff) == '0)
    else $error("Pull-up and pull-down together");

  a_alt_count: assert property (@(posedge hclk) disable iff (!hresetn)
    $countones(~oe_n_ff & ~$past(dir_ff)) <= 2)
    else $error("More than two alternate pins");

  a_wake_level: assert property (@(posedge hclk) disable iff (!hresetn)
    ((wake_en_ff & ~(pin_f_ff ^ wake_lvl_ff)) != '0) && $stable(pin_f_ff) |=> wake_ff)
    else $error("Wake level missed");

  a_drive_copy: assert property (@(posedge hclk) disable iff (!hresetn)
    !$stable(drive_ff) |=> drv_ff == $past(drive_ff))
    else $error("Drive strength not applied");

endmodule

// ===== rtl/gppwm_pkg.sv
/*
  Shared constants for the general pin unit with PWM and square-wave outputs.
  Assumes a single 40 MHz bus clock and an AHB-Lite register port.
*/
package gppwm_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int          NUM_PINS     = 8;
  localparam int          CLK_HZ       = 40_000_000;
  localparam int          TICK_HZ      = 1_000_000;
  localparam int          TICK_DIV     = CLK_HZ / TICK_HZ;
  localparam int          SQW_MAX_HZ   = 4_000_000;
  localparam int          SQW_MIN_HALF = (CLK_HZ + 2 * SQW_MAX_HZ - 1) / (2 * SQW_MAX_HZ);
  localparam int          RST_MIN_MS   = 100;
  localparam int          RST_MIN_CYC  = RST_MIN_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_DIR      = 8'h00;
  localparam logic [7:0]  REG_DOUT     = 8'h04;
  localparam logic [7:0]  REG_DRIVE    = 8'h08;
  localparam logic [7:0]  REG_PULL     = 8'h0C;
  localparam logic [7:0]  REG_WAKE_EN  = 8'h10;
  localparam logic [7:0]  REG_WAKE_LVL = 8'h14;
  localparam logic [7:0]  REG_FUNC     = 8'h18;
  localparam logic [7:0]  REG_PERIOD   = 8'h1C;
  localparam logic [7:0]  REG_DUTY0    = 8'h20;
  localparam logic [7:0]  REG_DUTY1    = 8'h24;
  localparam logic [7:0]  REG_SQW_HALF = 8'h28;
  localparam logic [7:0]  REG_STATUS   = 8'h2C;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          FUNC_CH_W    = 8;
  localparam int          FUNC_PIN_LSB = 0;
  localparam int          FUNC_MODE_LSB = 4;
  localparam int          STAT_WAKE    = 8;
  localparam int          STAT_CORE_RST = 9;
  localparam logic [1:0]  PULL_NONE    = 2'h0;
  localparam logic [1:0]  PULL_UP      = 2'h1;
  localparam logic [1:0]  PULL_DOWN    = 2'h2;
  localparam logic [7:0]  RST_PINS     = 8'h00;
  localparam logic [15:0] RST_PULL     = 16'h0000;
  localparam logic [15:0] RST_FUNC     = 16'h0000;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;

  typedef enum logic [1:0] {
    GPPWM_MODE_OFF = 2'b00,
    GPPWM_MODE_PWM = 2'b01,
    GPPWM_MODE_SQW = 2'b10
  } gppwm_mode_t;

endpackage

// ===== rtl/gppwm_pwm.sv
/*
  Two-channel PWM timer with one shared period and a duty per channel.
  Assumes a one-cycle tick pulse at 1 MHz from the same clock domain.
*/
`timescale 1ns/100ps
module gppwm_pwm
  import gppwm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        tick,
  input  wire logic [31:0] period,
  input  wire logic [31:0] duty0,
  input  wire logic [31:0] duty1,
  output logic      [1:0]  pwm_out
);

  logic [31:0] cnt_ff,    nxt_cnt;
  logic [31:0] per_sh_ff, nxt_per_sh;
  logic        bnd;

  // ----------------------------------------------------------------
  // Shared period counter
  // ----------------------------------------------------------------
  // Microsecond count
  always_comb begin
    bnd        = (per_sh_ff == 32'h0) | (tick & (cnt_ff == per_sh_ff - 32'h1));
    nxt_cnt    = cnt_ff;
    nxt_per_sh = per_sh_ff;
    if (bnd) begin
      nxt_cnt    = 32'h0;
      nxt_per_sh = period;
    end else if (tick) begin
      nxt_cnt = cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff    <= 32'h0;
      per_sh_ff <= 32'h0;
    end else begin
      cnt_ff    <= nxt_cnt;
      per_sh_ff <= nxt_per_sh;
    end
  end

  a_pwm_reload: assert property (@(posedge hclk) disable iff (!hresetn)
    !$stable(per_sh_ff) |-> cnt_ff == 32'h0)
    else $error("PWM period changed mid-period");

  a_pwm_tick: assert property (@(posedge hclk) disable iff (!hresetn)
    (cnt_ff != $past(cnt_ff)) && (cnt_ff != 32'h0) |-> $past(tick))
    else $error("PWM counter moved without a tick");

  // ----------------------------------------------------------------
  // Per-channel duty compare
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic [31:0] duty_sh_ff, nxt_duty_sh;
      logic        out_ff,     nxt_out;

      always_comb begin
        nxt_duty_sh = duty_sh_ff;
        if (bnd) begin
          nxt_duty_sh = (g == 0) ? duty0 : duty1;
        end
        nxt_out = (nxt_per_sh != 32'h0) & (nxt_cnt < nxt_duty_sh);
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          duty_sh_ff <= 32'h0;
          out_ff     <= 1'b0;
        end else begin
          duty_sh_ff <= nxt_duty_sh;
          out_ff     <= nxt_out;
        end
      end

      assign pwm_out[g] = out_ff;

      a_pwm_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (duty_sh_ff == 32'h0) |-> !out_ff)
        else $error("PWM pulse at zero duty");

      a_pwm_full: assert property (@(posedge hclk) disable iff (!hresetn)
        (per_sh_ff != 32'h0) && (duty_sh_ff >= per_sh_ff) |-> out_ff)
        else $error("PWM low at full duty");
    end
  endgenerate

endmodule

// ===== rtl/gppwm_sqw.sv
/*
  Square-wave generator with equal high and low halves.
  Assumes the half period is given in bus clock cycles; zero stops it low.
*/
`timescale 1ns/100ps
module gppwm_sqw
  import gppwm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [31:0] half_cyc,
  output logic             sqw_out
);

  logic [31:0] cnt_ff,  nxt_cnt;
  logic [31:0] half_ff, nxt_half;
  logic        out_ff,  nxt_out;
  logic [31:0] clamped;

  // ----------------------------------------------------------------
  // Half-period counter
  // ----------------------------------------------------------------
  // Clamp to the 4 MHz ceiling
  always_comb begin
    clamped  = (half_cyc != 32'h0 && half_cyc < 32'(SQW_MIN_HALF)) ? 32'(SQW_MIN_HALF) : half_cyc;
    nxt_cnt  = cnt_ff + 32'h1;
    nxt_half = half_ff;
    nxt_out  = out_ff;
    if (half_ff == 32'h0) begin
      nxt_cnt  = 32'h0;
      nxt_half = clamped;
      nxt_out  = 1'b0;
    end else if (cnt_ff == half_ff - 32'h1) begin
      nxt_cnt = 32'h0;
      // New rate only at a low-to-high edge keeps both halves equal
      if (!out_ff) begin
        nxt_half = clamped;
        nxt_out  = (clamped != 32'h0);
      end else begin
        nxt_out = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff  <= 32'h0;
      half_ff <= 32'h0;
      out_ff  <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      half_ff <= nxt_half;
      out_ff  <= nxt_out;
    end
  end

  assign sqw_out = out_ff;

  a_sqw_high_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(out_ff) |-> out_ff[*5])
    else $error("Square-wave high half too short");

  a_sqw_even: assert property (@(posedge hclk) disable iff (!hresetn)
    out_ff |-> ##1 (half_ff == $past(half_ff)))
    else $error("Square-wave half changed while high");

endmodule

// ===== tb/gppwm_pin_model.sv
/*
  External circuitry on the general pins: resolves each pad level.
  Assumes the unit's pin enables and one bench-controlled outside driver.
*/
`timescale 1ns/100ps
module gppwm_pin_model
  import gppwm_pkg::*;
(
  input  wire logic                hclk,
  input  wire logic [NUM_PINS-1:0] pin_out,
  input  wire logic [NUM_PINS-1:0] pin_oe_n,
  input  wire logic [NUM_PINS-1:0] pull_up,
  input  wire logic [NUM_PINS-1:0] pull_dn,
  input  wire logic [NUM_PINS-1:0] ext_val,
  input  wire logic [NUM_PINS-1:0] ext_en,
  output logic      [NUM_PINS-1:0] pin_lvl
);
  logic [NUM_PINS-1:0] wander_ff = '0;
  // Floating pads wander, so a stale level never reads back as valid
  always_ff @(posedge hclk) wander_ff <= ~wander_ff;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (!pin_oe_n[i]) pin_lvl[i] = pin_out[i];
      else if (ext_en[i]) pin_lvl[i] = ext_val[i];
      else if (pull_up[i]) pin_lvl[i] = 1'b1;
      else if (pull_dn[i]) pin_lvl[i] = 1'b0;
      else pin_lvl[i] = wander_ff[i];
    end
  end
endmodule

// ===== tb/tb_pin_pwm_square_wave_output_output.sv
/*
  Self-checking bench for the general pin unit.
  Assumes one AHB-Lite master (this bench) and a pad model on the pins.
*/
`timescale 1ns/100ps
module tb_pin_pwm_square_wave_output_output;
  import gppwm_pkg::*;
  localparam int RH = 20;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, wake_req, hw_reset_in_n, core_reset;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  pin_in, pout, poe_n, pdrv, ppu, ppd, ext_val, ext_en;
  int          fails, checks_done, h, e, dut0, eh;
  int          hv[3] = '{10, 2, 0};
  gppwm_top #(.RST_HOLD_CYC(RH)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .general_pin_in(pin_in),
    .general_pin_out(pout), .general_pin_oe_n(poe_n), .general_pin_drive_hi(pdrv),
    .general_pin_pull_up(ppu), .general_pin_pull_dn(ppd), .wake_req(wake_req),
    .hw_reset_in_n(hw_reset_in_n), .core_reset(core_reset));
  gppwm_pin_model u_pads (.hclk(hclk), .pin_out(pout), .pin_oe_n(poe_n), .pull_up(ppu),
    .pull_dn(ppd), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_in));
  always #12.5 hclk = ~hclk;
  // ----------------------------------------------------------------
  // Bus, wait and compare helpers
  // ----------------------------------------------------------------
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0; hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Counts high cycles and rising edges of one pin over n cycles
  task automatic count(input int p, input int n);
    logic prev;
    prev = pout[p]; h = 0; e = 0;
    repeat (n) begin
      @(posedge hclk); #1;
      h += int'(pout[p] === 1'b1);
      e += int'(pout[p] === 1'b1 && prev !== 1'b1);
      prev = pout[p];
    end
  endtask
  function automatic int pwm_hi(int per, int dut, int n);
    return dut >= per ? n : n / (per * TICK_DIV) * dut * TICK_DIV;
  endfunction
  task automatic final_report;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge hclk);
    fails++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
    ext_val = 0; ext_en = 8'h01; hw_reset_in_n = 1; fails = 0; checks_done = 0;
    void'($urandom(95358));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    settle(1);
    chk({16'h0, poe_n, pout}, 32'h0000_FF00);
    for (int a = 0; a <= 'h30; a += 4) if (a != REG_STATUS) begin
      ahb(0, 8'(a), 32'h0);
      chk(d, 32'h0);
      chk({31'h0, hresp}, 32'h0);
    end
    $display("test reset values done");
    repeat (4) begin
      eh = $urandom;
      ahb(1, REG_DIR, eh[7:0]); ahb(1, REG_DOUT, eh[15:8]); ahb(1, REG_DRIVE, eh[23:16]);
      settle(3);
      chk({8'h0, poe_n, pout, pdrv}, {8'h0, ~eh[7:0], eh[15:8], eh[23:16]});
    end
    ahb(1, REG_DIR, 32'h0);
    for (int k = 0; k < 4; k++) begin
      ahb(1, REG_PULL, {16{k[1:0]}});
      settle(6);
      chk({ppu, ppd}, {(k == 1) ? 8'hFF : 8'h00, (k == 2) ? 8'hFF : 8'h00});
      ahb(0, REG_STATUS, 32'h0);
      if (k == 1 || k == 2) chk({24'h0, d[7:1]}, (k == 1) ? 32'h7F : 32'h0);
    end
    $display("test pin config done");
    ahb(1, REG_WAKE_EN, 32'h1);
    for (int j = 0; j < 4; j++) begin
      ahb(1, REG_WAKE_LVL, 32'(j / 2));
      @(posedge hclk); ext_val <= 8'(j % 2);
      settle(8);
      chk({31'h0, wake_req}, 32'((j / 2) == (j % 2)));
    end
    $display("test wake done");
    @(posedge hclk); hw_reset_in_n <= 1'b0;
    settle(8);
    @(posedge hclk); hw_reset_in_n <= 1'b1;
    settle(10);
    chk({31'h0, core_reset}, 32'h0);
    ahb(1, REG_DIR, 32'hFF);
    @(posedge hclk); hw_reset_in_n <= 1'b0;
    settle(RH + 12);
    chk({31'h0, core_reset}, 32'h1);
    @(posedge hclk); hw_reset_in_n <= 1'b1;
    settle(10);
    ahb(0, REG_DIR, 32'h0);
    chk(d, 32'h0);
    $display("test reset pin done");
    ahb(1, REG_DIR, 32'h1); ahb(1, REG_DOUT, 32'h1); ahb(1, REG_PERIOD, 32'h4); ahb(1, REG_DUTY1, 32'h4);
    ahb(1, REG_FUNC, 32'h0000_1512);
    for (int j = 0; j < 2; j++) begin
      dut0 = (j == 0) ? 0 : $urandom_range(3, 1);
      ahb(1, REG_DUTY0, 32'(dut0));
      settle(400);
      count(2, 320);
      chk(32'(h), 32'(pwm_hi(4, dut0, 320)));
      count(5, 320);
      chk(32'(h), 32'(pwm_hi(4, 4, 320)));
      chk({30'h0, poe_n[2], pout[0]}, 32'h1);
    end
    $display("test pwm done");
    for (int j = 0; j < 3; j++) begin
      ahb(1, REG_SQW_HALF, 32'(hv[j])); ahb(1, REG_FUNC, 32'h0000_1222);
      settle(100);
      count(2, 200);
      eh = (hv[j] == 0) ? 0 : (hv[j] < SQW_MIN_HALF ? SQW_MIN_HALF : hv[j]);
      chk({16'(h), 16'(e)}, (eh == 0) ? 32'h0 : {16'd100, 16'(200 / (2 * eh))});
    end
    $display("test square wave done");
    final_report();
  end
endmodule
